// *** verilog/fbpl_pkg.sv ***
package fbpl_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [3:0] IDX_EESAVE   = 4'h5;
  localparam logic [3:0] IDX_STARTUP  = 4'h6;
  localparam logic [3:0] IDX_APP_END  = 4'h7;
  localparam logic [3:0] IDX_BOOT_END = 4'h8;
  localparam logic [3:0] IDX_LOCK     = 4'hA;
  localparam logic [3:0] IDX_STATUS   = 4'hB;

  // Field positions.
  localparam int unsigned EESAVE_BIT  = 0;
  localparam int unsigned SUT_MSB     = 2;
  localparam int unsigned ST_LOADED   = 0;
  localparam int unsigned ST_RUNNING  = 1;
  localparam int unsigned ST_LOCKED   = 2;
  localparam int unsigned ST_EESAVE   = 3;

  // Reset values and the unlock key.
  localparam logic [7:0] LOCK_KEY     = 8'hC5;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [2:0] SUT_RST      = 3'h0;

  // Last fuse load step; five fuse bytes are fetched at start-up.
  localparam logic [2:0] FUSE_LAST    = 3'h4;

  // Timing: one millisecond of start-up delay at the core clock rate.
  localparam int unsigned T_MS_NS      = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_CYC_DEF   = T_MS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SECT_BOOT = 2'h0,
    SECT_APP  = 2'h1,
    SECT_DATA = 2'h2
  } fbpl_sect_t;

  typedef enum logic [1:0] {
    ST_LOAD  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b11
  } fbpl_state_t;

  // Byte address of a limit given in 256-byte blocks.
  function automatic logic [15:0] blk_base(input logic [7:0] lim);
    blk_base = {lim, 8'h00};
  endfunction : blk_base

  // Fuse offset fetched at each load step.
  function automatic logic [3:0] fuse_off(input logic [2:0] step);
    unique case (step)
      3'h0:    fuse_off = IDX_EESAVE;
      3'h1:    fuse_off = IDX_STARTUP;
      3'h2:    fuse_off = IDX_APP_END;
      3'h3:    fuse_off = IDX_BOOT_END;
      default: fuse_off = IDX_LOCK;
    endcase
  endfunction : fuse_off

endpackage : fbpl_pkg

// *** verilog/fbpl_part_map.sv ***
`timescale 1ns/1ns
`default_nettype none
module fbpl_part_map
  import fbpl_pkg::*;
(
  input  wire logic [7:0]  boot_lim_i,
  input  wire logic [7:0]  app_lim_i,
  input  wire logic [15:0] addr_i,
  output fbpl_sect_t       sect_o
);

  logic [15:0] boot_top;
  logic [15:0] app_top;

  assign boot_top = blk_base(boot_lim_i);
  assign app_top  = blk_base(app_lim_i);

  always_comb begin
    if (boot_lim_i == BYTE_RST) begin
      sect_o = SECT_BOOT; // [R6] [R7]
    end else if (addr_i < boot_top) begin
      sect_o = SECT_BOOT; // [R5] [R12]
    end else if (app_lim_i == BYTE_RST) begin
      sect_o = SECT_APP; // [R4]
    end else if (addr_i < app_top) begin
      sect_o = SECT_APP; // [R2] [R12]
    end else begin
      sect_o = SECT_DATA; // [R3]
    end
  end

endmodule : fbpl_part_map
`default_nettype wire

// *** verilog/fbpl_top.sv ***
// How it works
// [R1] Start-up code 0..7 holds code execution for 0,1,2,4,8,16,32,64 ms.
// [R2] Application end byte marks code end in 256-byte blocks from flash start.
// [R3] Flash above the application code end is application data.
// [R4] Application end zero makes all flash above boot end application code.
// [R5] Boot end byte sets the boot section top in 256-byte blocks.
// [R6] Boot end zero makes the whole flash the boot section.
// [R7] Both limits zero means every address is boot.
// [R8] Only lock key 0xC5 unlocks; any other value locks.
// [R9] Locked debug port gets no bus access, only the info block.
// [R10] Each fuse byte is copied into its configuration fields at start-up.
// [R11] Locked chip erase always erases data memory, ignoring the save bit.
// [R12] Below boot top is boot, below app top is code, rest data.
// [R13] Fuses are decoded once after reset and held until next reset; a lock register write other than 0xC5 sets the lock at once.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module fbpl_top
  import fbpl_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC_DEF
) (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        clk_en_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Fuse row read port.
  output logic             fuse_rd_o,
  output logic [3:0]       fuse_addr_o,
  input  wire logic        fuse_ack_i,
  input  wire logic [7:0]  fuse_data_i,
  // Start-up outputs.
  output logic             cfg_valid_o,
  output logic             cpu_run_o,
  output logic [2:0]       startup_delay_sel_o,
  output logic [7:0]       app_code_limit_o,
  output logic [7:0]       boot_code_limit_o,
  output logic             eesave_o,
  // Flash access control.
  input  wire logic [15:0] flash_addr_i,
  output logic [1:0]       flash_sect_o,
  // Single-pin debug port.
  input  wire logic        dbg_req_i,
  input  wire logic        dbg_sib_i,
  output logic             dbg_grant_o,
  output logic             dbg_deny_o,
  output logic             locked_o,
  // Chip erase.
  input  wire logic        chip_erase_i,
  output logic             erase_eeprom_o
);

  typedef struct packed {
    fbpl_state_t state;
    logic [2:0]  step;
    logic        rd_pend;
    logic        fuse_rd;
    logic [3:0]  fuse_addr;
    logic        eesave;
    logic [2:0]  startup_delay_sel;
    logic [7:0]  app_lim;
    logic [7:0]  boot_lim;
    logic [7:0]  key;
    logic [7:0]  key_pend;
    logic        cfg_valid;
    logic        locked;
    logic [31:0] cnt;
    logic        run;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [1:0]  sect;
    logic        grant;
    logic        deny;
    logic        erase_ee;
  } fbpl_state_s_t;

  fbpl_state_s_t q_r;
  fbpl_state_s_t q_nxt;

  fbpl_sect_t  sect_w;
  logic [31:0] delay_w;
  logic [3:0]  idx_w;
  logic        map_w;
  logic        ro_w;
  logic        loaded_w;
  logic [31:0] rd_w;

  // Delay in cycles for a start-up code; each step doubles from one millisecond.
  function automatic logic [31:0] delay_cyc(input logic [2:0] sel);
    logic [31:0] base;
    base = 32'(MS_CYCLES);
    if (sel == SUT_RST) begin
      delay_cyc = 32'h0000_0000;
    end else begin
      delay_cyc = base << (sel - 3'h1);
    end
  endfunction : delay_cyc

  fbpl_part_map u_map (
    .boot_lim_i (q_r.boot_lim),
    .app_lim_i  (q_r.app_lim),
    .addr_i     (flash_addr_i),
    .sect_o     (sect_w)
  );

  assign delay_w  = delay_cyc(q_r.startup_delay_sel); // [R1]
  assign loaded_w = q_r.cfg_valid;
  assign idx_w    = paddr_i[5:2];
  assign map_w    = (paddr_i[11:6] == 6'h00) && (paddr_i[1:0] == 2'h0) &&
                    ((idx_w == IDX_EESAVE) || (idx_w == IDX_STARTUP) ||
                     (idx_w == IDX_APP_END) || (idx_w == IDX_BOOT_END) ||
                     (idx_w == IDX_LOCK) || (idx_w == IDX_STATUS));
  assign ro_w     = (idx_w != IDX_LOCK);

  always_comb begin
    rd_w = 32'h0000_0000;
    unique case (idx_w)
      IDX_EESAVE: begin
        rd_w[EESAVE_BIT] = q_r.eesave;
      end
      IDX_STARTUP: begin
        rd_w[SUT_MSB:0] = q_r.startup_delay_sel;
      end
      IDX_APP_END: begin
        rd_w[7:0] = q_r.app_lim;
      end
      IDX_BOOT_END: begin
        rd_w[7:0] = q_r.boot_lim;
      end
      IDX_LOCK: begin
        rd_w[7:0] = q_r.key_pend;
      end
      IDX_STATUS: begin
        rd_w[ST_LOADED]  = loaded_w;
        rd_w[ST_RUNNING] = q_r.run;
        rd_w[ST_LOCKED]  = q_r.locked;
        rd_w[ST_EESAVE]  = q_r.eesave;
      end
      default: begin
        rd_w = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    q_nxt = q_r;
    q_nxt.fuse_rd = 1'b0;

    // Fuse fetch and start-up sequence.
    unique case (q_r.state)
      ST_LOAD: begin
        if (!q_r.rd_pend) begin
          q_nxt.fuse_rd   = 1'b1;
          q_nxt.fuse_addr = fuse_off(q_r.step);
          q_nxt.rd_pend   = 1'b1;
        end else if (fuse_ack_i) begin
          q_nxt.rd_pend = 1'b0;
          unique case (q_r.step)
            3'h0: begin
              q_nxt.eesave = fuse_data_i[EESAVE_BIT]; // [R10]
            end
            3'h1: begin
              q_nxt.startup_delay_sel = fuse_data_i[SUT_MSB:0]; // [R10]
            end
            3'h2: begin
              q_nxt.app_lim = fuse_data_i; // [R10]
            end
            3'h3: begin
              q_nxt.boot_lim = fuse_data_i; // [R10]
            end
            default: begin
              q_nxt.key      = fuse_data_i; // [R10]
              q_nxt.key_pend = fuse_data_i;
              q_nxt.locked   = (fuse_data_i != LOCK_KEY); // [R8]
            end
          endcase
          if (q_r.step == FUSE_LAST) begin
            q_nxt.state     = ST_DELAY; // [R13]
            q_nxt.cfg_valid = 1'b1;
            q_nxt.cnt   = 32'h0000_0000;
          end else begin
            q_nxt.step = q_r.step + 3'h1;
          end
        end
      end
      ST_DELAY: begin
        if (q_r.cnt >= delay_w) begin
          q_nxt.state = ST_RUN; // [R1]
          q_nxt.run   = 1'b1;
        end else begin
          q_nxt.cnt = q_r.cnt + 32'h0000_0001;
        end
      end
      ST_RUN: begin
        q_nxt.run = 1'b1; // [R13]
      end
      default: begin
        q_nxt.state = ST_LOAD;
      end
    endcase

    // Flash section of the presented address, one cycle later.
    q_nxt.sect = sect_w; // [R12]

    // Debug port gating; before the key is known the port counts as locked.
    q_nxt.grant = dbg_req_i && (!q_r.locked || dbg_sib_i); // [R9]
    q_nxt.deny  = dbg_req_i && q_r.locked && !dbg_sib_i; // [R9]

    // The save bit only protects data memory while the part is unlocked.
    q_nxt.erase_ee = chip_erase_i && (q_r.locked || !q_r.eesave); // [R11]

    // APB: answer one cycle into the access phase, act on completion.
    q_nxt.pready = 1'b0;
    if (psel_i && penable_i && !q_r.pready) begin
      q_nxt.pready  = 1'b1;
      q_nxt.pslverr = !map_w || (pwrite_i && ro_w);
      q_nxt.prdata  = (map_w && !pwrite_i) ? rd_w : 32'h0000_0000;
    end
    if (psel_i && penable_i && q_r.pready) begin
      if (pwrite_i && map_w && !ro_w) begin
        q_nxt.key_pend = pwdata_i[7:0];
        // Locking takes effect at once; unlocking waits for the next load.
        if (pwdata_i[7:0] != LOCK_KEY) begin
          q_nxt.locked = 1'b1; // [R8]
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      q_r.state     <= ST_LOAD;
      q_r.step      <= 3'h0;
      q_r.rd_pend   <= 1'b0;
      q_r.fuse_rd   <= 1'b0;
      q_r.fuse_addr <= 4'h0;
      q_r.eesave    <= 1'b0;
      q_r.startup_delay_sel       <= SUT_RST;
      q_r.app_lim   <= BYTE_RST;
      q_r.boot_lim  <= BYTE_RST;
      q_r.key       <= BYTE_RST;
      q_r.key_pend  <= BYTE_RST;
      q_r.cfg_valid <= 1'b0;
      q_r.locked    <= 1'b1;
      q_r.cnt       <= 32'h0000_0000;
      q_r.run       <= 1'b0;
      q_r.pready    <= 1'b0;
      q_r.prdata    <= 32'h0000_0000;
      q_r.pslverr   <= 1'b0;
      q_r.sect      <= SECT_BOOT;
      q_r.grant     <= 1'b0;
      q_r.deny      <= 1'b0;
      q_r.erase_ee  <= 1'b0;
    end else if (clk_en_i) begin
      q_r <= q_nxt;
    end
  end

  assign pready_o            = q_r.pready;
  assign prdata_o            = q_r.prdata;
  assign pslverr_o           = q_r.pslverr;
  assign fuse_rd_o           = q_r.fuse_rd;
  assign fuse_addr_o         = q_r.fuse_addr;
  assign cfg_valid_o         = q_r.cfg_valid;
  assign cpu_run_o           = q_r.run;
  assign startup_delay_sel_o = q_r.startup_delay_sel;
  assign app_code_limit_o    = q_r.app_lim;
  assign boot_code_limit_o   = q_r.boot_lim;
  assign eesave_o            = q_r.eesave;
  assign flash_sect_o        = q_r.sect;
  assign dbg_grant_o         = q_r.grant;
  assign dbg_deny_o          = q_r.deny;
  assign locked_o            = q_r.locked;
  assign erase_eeprom_o      = q_r.erase_ee;

endmodule : fbpl_top
`default_nettype wire

// *** tb/fbpl_fuse_row.sv ***
`timescale 1ns/1ns
`default_nettype none
module fbpl_fuse_row (
  input  wire logic       clk_i,
  input  wire logic       rd_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [1:0] lat_i,
  output logic            ack_o,
  output logic [7:0]      data_o
);
  logic [7:0] mem [16];
  // Between answers the data lines show the inverse of the last byte (0x5A before the first), so stale bytes never pass.
  initial begin
    ack_o = 1'b0;
    data_o = 8'h5A;
    forever begin
      @(posedge clk_i);
      if (rd_i) begin
        repeat (lat_i) @(posedge clk_i);
        ack_o <= 1'b1;
        data_o <= mem[addr_i];
        @(posedge clk_i);
        ack_o <= 1'b0;
        data_o <= ~mem[addr_i];
      end
    end
  end
endmodule : fbpl_fuse_row
`default_nettype wire

// *** tb/fbpl_top_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module fbpl_top_chk
  import fbpl_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        clk_en_i,
  input wire logic        cfg_valid_o,
  input wire logic        cpu_run_o,
  input wire logic [7:0]  boot_code_limit_o,
  input wire logic [15:0] flash_addr_i,
  input wire logic [1:0]  flash_sect_o,
  input wire logic        dbg_req_i,
  input wire logic        dbg_sib_i,
  input wire logic        dbg_grant_o,
  input wire logic        dbg_deny_o,
  input wire logic        locked_o,
  input wire logic        chip_erase_i,
  input wire logic        erase_eeprom_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  dbg_deny_a: assert property (clk_en_i && dbg_req_i && locked_o && !dbg_sib_i
    |=> dbg_deny_o && !dbg_grant_o) else $error("locked access not denied");
  dbg_grant_a: assert property (clk_en_i && dbg_req_i && (!locked_o || dbg_sib_i)
    |=> dbg_grant_o && !dbg_deny_o) else $error("access not granted");
  erase_lock_a: assert property (clk_en_i && chip_erase_i && locked_o
    |=> erase_eeprom_o) else $error("locked erase kept data memory");
  run_hold_a: assert property (cpu_run_o |=> cpu_run_o)
    else $error("run dropped");
  cfg_hold_a: assert property (cfg_valid_o |=> cfg_valid_o && $stable(boot_code_limit_o))
    else $error("config changed");
  run_early_a: assert property (!cfg_valid_o |-> !cpu_run_o)
    else $error("run before config");
  boot_zero_a: assert property (clk_en_i && cfg_valid_o && boot_code_limit_o == BYTE_RST
    |=> flash_sect_o == 2'h0) else $error("not all boot");
  boot_low_a: assert property (clk_en_i && flash_addr_i[15:8] < boot_code_limit_o
    |=> flash_sect_o == 2'h0) else $error("low address not boot");
endmodule : fbpl_top_chk
`default_nettype wire
bind fbpl_top fbpl_top_chk chk (.core_clk_i, .resetn_i, .clk_en_i, .cfg_valid_o, .cpu_run_o,
  .boot_code_limit_o, .flash_addr_i, .flash_sect_o, .dbg_req_i, .dbg_sib_i, .dbg_grant_o,
  .dbg_deny_o, .locked_o, .chip_erase_i, .erase_eeprom_o);

// *** tb/fbpl_top_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module fbpl_top_tb_top
  import fbpl_pkg::*;
;
  localparam int MS = 4;
  typedef struct packed {
    logic [11:0] a;
    logic        w;
    logic [7:0]  q;
    logic        e;
    logic [15:0] fa;
    logic [1:0]  fs;
  } fbpl_row_t;
  logic        core_clk_i = 1'b0;
  logic        resetn_i, clk_en_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic        fuse_rd_o, fuse_ack_i, cfg_valid_o, cpu_run_o, eesave_o, e;
  logic [3:0]  fuse_addr_o;
  logic [7:0]  fuse_data_i, app_code_limit_o, boot_code_limit_o;
  logic [2:0]  startup_delay_sel_o;
  logic [15:0] flash_addr_i;
  logic [1:0]  flash_sect_o, lat;
  logic        dbg_req_i, dbg_sib_i, dbg_grant_o, dbg_deny_o, locked_o;
  logic        chip_erase_i, erase_eeprom_o;
  int          err_total = 0;
  int          cmp_count = 0;
  fbpl_row_t   rows [8] = '{
    '{12'h018, 1'b0, 8'h02, 1'b0, 16'h0000, 2'h0}, '{12'h01C, 1'b0, 8'h08, 1'b0, 16'h03FF, 2'h0},
    '{12'h020, 1'b0, 8'h04, 1'b0, 16'h0400, 2'h1}, '{12'h028, 1'b0, 8'hC5, 1'b0, 16'h07FF, 2'h1},
    '{12'h02C, 1'b0, 8'h0B, 1'b0, 16'h0800, 2'h2}, '{12'h024, 1'b0, 8'h00, 1'b1, 16'hFFFF, 2'h2},
    '{12'h02E, 1'b0, 8'h00, 1'b1, 16'h0000, 2'h0}, '{12'h018, 1'b1, 8'h00, 1'b1, 16'h0100, 2'h0}};

  always #10 core_clk_i = ~core_clk_i;

  fbpl_top #(.MS_CYCLES(MS)) dut (.core_clk_i, .resetn_i, .clk_en_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .fuse_rd_o, .fuse_addr_o,
    .fuse_ack_i, .fuse_data_i, .cfg_valid_o, .cpu_run_o, .startup_delay_sel_o,
    .app_code_limit_o, .boot_code_limit_o, .eesave_o, .flash_addr_i, .flash_sect_o, .dbg_req_i,
    .dbg_sib_i, .dbg_grant_o, .dbg_deny_o, .locked_o, .chip_erase_i, .erase_eeprom_o);
  fbpl_fuse_row fuse (.clk_i(core_clk_i), .rd_i(fuse_rd_o), .addr_i(fuse_addr_o), .lat_i(lat),
    .ack_o(fuse_ack_i), .data_o(fuse_data_i));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // Look at pready between edges, where it has settled, then act on the next edge.
    do begin
      @(negedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    @(posedge core_clk_i);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic boot_up(input logic [7:0] es, su, ap, bo, ky, input logic [1:0] l);
    int n;
    int d;
    fuse.mem[5] = es;
    fuse.mem[6] = su;
    fuse.mem[7] = ap;
    fuse.mem[8] = bo;
    fuse.mem[10] = ky;
    lat = l;
    d = (su[2:0] == 3'h0) ? 0 : MS << (su[2:0] - 3'h1);
    resetn_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    chk("run_in_reset", {31'h0, cpu_run_o}, 32'h0);
    resetn_i <= 1'b1;
    n = 0;
    while (cfg_valid_o !== 1'b1 && n < 100) begin
      @(posedge core_clk_i);
      n++;
    end
    n = 0;
    while (cpu_run_o !== 1'b1 && n < 600) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("run_delay", {31'h0, n >= d && n <= d + 2}, 32'h1);
    chk("fields", {eesave_o, startup_delay_sel_o, app_code_limit_o, boot_code_limit_o},
      {es[0], su[2:0], ap, bo});
    chk("locked", {31'h0, locked_o}, {31'h0, ky != LOCK_KEY});
    $display("test load sut %0d done", su[2:0]);
  endtask : boot_up

  task automatic sect(input logic [15:0] fa, input logic [1:0] fs);
    flash_addr_i <= fa;
    repeat (2) @(posedge core_clk_i);
    chk("sect", {30'h0, flash_sect_o}, {30'h0, fs});
  endtask : sect

  // The limit allows every load with the longest delay code plus margin.
  initial begin
    repeat (5000) @(posedge core_clk_i);
    err_total++;
    complete_run();
  end

  initial begin
    resetn_i = 1'b0;
    clk_en_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    flash_addr_i = 16'h0000;
    dbg_req_i = 1'b0;
    dbg_sib_i = 1'b0;
    chip_erase_i = 1'b0;
    lat = 2'h0;
    @(posedge core_clk_i);
    boot_up(8'h01, 8'hFA, 8'h08, 8'h04, LOCK_KEY, 2'h2);
    foreach (rows[i]) begin
      flash_addr_i <= rows[i].fa;
      apb(rows[i].w, rows[i].a, 8'hFF);
      if (!rows[i].w) chk("rdata", q, {24'h0, rows[i].q});
      chk("slverr", {31'h0, e}, {31'h0, rows[i].e});
      chk("sect", {30'h0, flash_sect_o}, {30'h0, rows[i].fs});
    end
    $display("test table done");
    dbg_req_i <= 1'b1;
    chip_erase_i <= 1'b1;
    @(posedge core_clk_i);
    chip_erase_i <= 1'b0;
    @(negedge core_clk_i);
    chk("open", {dbg_grant_o, dbg_deny_o, erase_eeprom_o}, 32'h4);
    apb(1'b1, 12'h028, 8'h00);
    @(posedge core_clk_i);
    chk("lock_wr", {e, locked_o}, 32'h1);
    chip_erase_i <= 1'b1;
    @(posedge core_clk_i);
    chip_erase_i <= 1'b0;
    dbg_sib_i <= 1'b1;
    @(negedge core_clk_i);
    chk("deny", {dbg_grant_o, dbg_deny_o, erase_eeprom_o}, 32'h3);
    @(negedge core_clk_i);
    chk("info", {dbg_grant_o, dbg_deny_o}, 32'h2);
    // With the enable low the grant must hold although the request has gone.
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    dbg_req_i <= 1'b0;
    dbg_sib_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("freeze", {dbg_grant_o, dbg_deny_o}, 32'h2);
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    $display("test debug done");
    boot_up(8'h00, 8'h00, 8'h00, 8'h02, LOCK_KEY, 2'h0);
    sect(16'h01FF, 2'h0);
    sect(16'h0200, 2'h1);
    sect(16'hFFFF, 2'h1);
    boot_up(8'h00, 8'h01, 8'h10, 8'h00, 8'hC4, 2'h1);
    sect(16'hF000, 2'h0);
    for (int s = 0; s < 8; s++) begin
      boot_up(8'h00, 8'(s), 8'h00, 8'h00, s[0] ? 8'hC4 : LOCK_KEY, 2'(s % 3));
      sect(16'hC000, 2'h0);
    end
    complete_run();
  end
endmodule : fbpl_top_tb_top
`default_nettype wire
